/* File: core/pos_pin_group.sv */
// one pin group: direction, shared output value storage and pull enables
`timescale 1ns/1ps
module pos_pin_group
   import pos_pkg::*;
(
   input  wire logic                  clk,
   input  wire logic                  rst,
   input  wire logic                  wr_en,
   input  pos_reg_type                wr_reg,
   input  wire logic [31:0]           wdata,
   output logic      [GROUP_PINS-1:0] nxt_dir,
   output logic      [GROUP_PINS-1:0] nxt_out,
   output logic      [GROUP_PINS-1:0] nxt_pull,
   output logic      [GROUP_PINS-1:0] dir_ff,
   output logic      [GROUP_PINS-1:0] out_ff,
   output logic      [GROUP_PINS-1:0] pull_up_ff,
   output logic      [GROUP_PINS-1:0] pull_down_ff
);
   logic [GROUP_PINS-1:0] pull_ff;
   logic [GROUP_PINS-1:0] wmask;
   logic [GROUP_PINS-1:0] pull_up_nxt;
   logic [GROUP_PINS-1:0] pull_down_nxt;

   assign wmask = wdata[GROUP_PINS-1:0];

   assign nxt_dir  = (wr_en && wr_reg == REG_DIR)  ? wmask : dir_ff;
   assign nxt_pull = (wr_en && wr_reg == REG_PULL) ? wmask : pull_ff;
   // all four views act on out_ff alone, so no view can go stale
   assign nxt_out  = !wr_en              ? out_ff :
                     wr_reg == REG_OUT   ? wmask :
                     wr_reg == REG_SET   ? (out_ff | wmask) :
                     wr_reg == REG_CLR   ? (out_ff & ~wmask) :
                     wr_reg == REG_TGL   ? (out_ff ^ wmask) :
                     out_ff;

   // pulls follow next state so pad flops never lag the value flops
   assign pull_up_nxt   = ~nxt_dir & nxt_pull & nxt_out;
   assign pull_down_nxt = ~nxt_dir & nxt_pull & ~nxt_out;

   always_ff @(posedge clk) begin
      if (rst) begin
         dir_ff       <= DIR_RESET;
         out_ff       <= OUT_RESET;
         pull_ff      <= PULL_RESET;
         pull_up_ff   <= PULL_RESET;
         pull_down_ff <= PULL_RESET;
      end else begin
         dir_ff       <= nxt_dir;
         out_ff       <= nxt_out;
         pull_ff      <= nxt_pull;
         pull_up_ff   <= pull_up_nxt;
         pull_down_ff <= pull_down_nxt;
      end
   end
endmodule : pos_pin_group

/* File: core/pos_pkg.sv */
// shared constants and types for the port output set block
package pos_pkg;
   localparam int GROUP_PINS  = 32;
   localparam int NUM_GROUPS  = 2;
   localparam int GROUP_SHIFT = 7;
   localparam int GROUP_IDX_W = 1;
   localparam int OFS_W       = 7;
   localparam int MAP_TOP_LSB = GROUP_SHIFT + GROUP_IDX_W;
   localparam int PIN_TOTAL   = GROUP_PINS * NUM_GROUPS;

   localparam logic [31:0]      GROUP_STRIDE = 32'h0000_0080;
   localparam logic [OFS_W-1:0] OFS_DIR      = 7'h00;
   localparam logic [OFS_W-1:0] OFS_OUT      = 7'h10;
   localparam logic [OFS_W-1:0] OFS_CLR      = 7'h14;
   localparam logic [OFS_W-1:0] OFS_SET      = 7'h18;
   localparam logic [OFS_W-1:0] OFS_TGL      = 7'h1c;
   localparam logic [OFS_W-1:0] OFS_PULL     = 7'h20;

   localparam logic [GROUP_PINS-1:0] DIR_RESET  = 32'h0000_0000;
   localparam logic [GROUP_PINS-1:0] OUT_RESET  = 32'h0000_0000;
   localparam logic [GROUP_PINS-1:0] PULL_RESET = 32'h0000_0000;
   localparam logic [31:0]           RDATA_ZERO = 32'h0000_0000;

   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic       HRESP_OKAY    = 1'h0;

   typedef enum logic [2:0] {
      REG_NONE = 3'b000,
      REG_DIR  = 3'b001,
      REG_OUT  = 3'b010,
      REG_CLR  = 3'b011,
      REG_SET  = 3'b100,
      REG_TGL  = 3'b101,
      REG_PULL = 3'b110
   } pos_reg_type;
endpackage : pos_pkg

/* File: core/pos_port_output_set.sv */
// gpio port output value block with set view, reached over ahb-lite
//
// Summary of operation
// - a one in a set-register mask drives that pin's output value high
// - set, clear, toggle and value registers are views of one storage
// - pins come in groups of at most 32, group zero first
// - every group has a full register copy, group bases 0x80 apart
// - set register decodes at 0x18 in each group, reads zero after reset
// - output value one drives high, or selects pull-up on pulled input
`timescale 1ns/1ps
module pos_port_output_set
   import pos_pkg::*;
(
   input  wire logic                 SYS_CLK,
   input  wire logic                 RESET,
   input  wire logic                 HSEL,
   input  wire logic [31:0]          HADDR,
   input  wire logic [1:0]           HTRANS,
   input  wire logic                 HWRITE,
   input  wire logic [2:0]           HSIZE,
   input  wire logic [31:0]          HWDATA,
   input  wire logic                 HREADY,
   output logic      [31:0]          HRDATA,
   output logic                      HREADYOUT,
   output logic                      HRESP,
   output logic      [PIN_TOTAL-1:0] PAD_OUT,
   output logic      [PIN_TOTAL-1:0] PAD_OE,
   output logic      [PIN_TOTAL-1:0] PAD_PULL_UP,
   output logic      [PIN_TOTAL-1:0] PAD_PULL_DOWN
);
   // offset within a group to register view
   function automatic pos_reg_type decode_view(input logic [OFS_W-1:0] ofs);
      if (ofs == OFS_DIR)
         return REG_DIR;
      else if (ofs == OFS_OUT)
         return REG_OUT;
      else if (ofs == OFS_CLR)
         return REG_CLR;
      else if (ofs == OFS_SET)
         return REG_SET;
      else if (ofs == OFS_TGL)
         return REG_TGL;
      else if (ofs == OFS_PULL)
         return REG_PULL;
      else
         return REG_NONE;
   endfunction : decode_view

   logic [GROUP_PINS-1:0] g_nxt_dir  [NUM_GROUPS];
   logic [GROUP_PINS-1:0] g_nxt_out  [NUM_GROUPS];
   logic [GROUP_PINS-1:0] g_nxt_pull [NUM_GROUPS];
   logic [GROUP_PINS-1:0] g_out      [NUM_GROUPS];

   logic                   dp_write_ff;
   pos_reg_type            dp_reg_ff;
   logic [GROUP_IDX_W-1:0] dp_grp_ff;
   logic [31:0]            hrdata_ff;
   logic                   hreadyout_ff;

   wire                   addr_take;
   wire                   addr_in_map;
   wire [GROUP_IDX_W-1:0] addr_grp;
   wire pos_reg_type      addr_reg;
   wire [31:0]            read_view;

   assign addr_take   = HSEL && HREADY && HTRANS == HTRANS_NONSEQ;
   // only groups that exist answer; higher addresses read zero
   assign addr_in_map = HADDR[31:MAP_TOP_LSB] == '0;
   assign addr_grp    = HADDR[GROUP_SHIFT +: GROUP_IDX_W];
   assign addr_reg    = addr_in_map ? decode_view(HADDR[OFS_W-1:0]) : REG_NONE;

   // read from next state so a read right behind a write sees it
   assign read_view = (addr_reg == REG_DIR)  ? g_nxt_dir[addr_grp] :
                      (addr_reg == REG_PULL) ? g_nxt_pull[addr_grp] :
                      (addr_reg == REG_NONE) ? RDATA_ZERO :
                      g_nxt_out[addr_grp];

   always_ff @(posedge SYS_CLK) begin
      if (RESET) begin
         dp_write_ff  <= 1'b0;
         dp_reg_ff    <= REG_NONE;
         dp_grp_ff    <= '0;
         hrdata_ff    <= RDATA_ZERO;
         hreadyout_ff <= 1'b0;
      end else begin
         hreadyout_ff <= 1'b1;
         dp_write_ff  <= addr_take && HWRITE;
         dp_reg_ff    <= addr_reg;
         dp_grp_ff    <= addr_grp;
         if (addr_take && !HWRITE) begin
            hrdata_ff <= read_view;
         end
      end
   end

   assign HRDATA    = hrdata_ff;
   assign HREADYOUT = hreadyout_ff;
   assign HRESP     = HRESP_OKAY;

   genvar g;
   generate
      for (g = 0; g < NUM_GROUPS; g++) begin : grp
         logic wr_en;
         assign wr_en = dp_write_ff && dp_grp_ff == GROUP_IDX_W'(g);
         pos_pin_group u_group (
            .clk          (SYS_CLK),
            .rst          (RESET),
            .wr_en        (wr_en),
            .wr_reg       (dp_reg_ff),
            .wdata        (HWDATA),
            .nxt_dir      (g_nxt_dir[g]),
            .nxt_out      (g_nxt_out[g]),
            .nxt_pull     (g_nxt_pull[g]),
            .dir_ff       (PAD_OE[g*GROUP_PINS +: GROUP_PINS]),
            .out_ff       (g_out[g]),
            .pull_up_ff   (PAD_PULL_UP[g*GROUP_PINS +: GROUP_PINS]),
            .pull_down_ff (PAD_PULL_DOWN[g*GROUP_PINS +: GROUP_PINS])
         );
         assign PAD_OUT[g*GROUP_PINS +: GROUP_PINS] = g_out[g];
      end
   endgenerate

   // checks below watch only what this block drives
   wire                  set_wr  = dp_write_ff && dp_reg_ff == REG_SET;
   wire [GROUP_PINS-1:0] g0_out  = g_out[0];
   wire [GROUP_PINS-1:0] g1_pad  = PAD_OUT[PIN_TOTAL-1 -: GROUP_PINS];
   wire [GROUP_PINS-1:0] g0_oe   = PAD_OE[GROUP_PINS-1:0];
   wire [GROUP_PINS-1:0] g0_pu   = PAD_PULL_UP[GROUP_PINS-1:0];
   wire [GROUP_PINS-1:0] g0_pd   = PAD_PULL_DOWN[GROUP_PINS-1:0];
   wire                  set_rd  = addr_take && !HWRITE && addr_reg == REG_SET;
   wire                  outv_rd = addr_take && !HWRITE && addr_reg == REG_OUT;
   logic                 rst_q_ff;
   always_ff @(posedge SYS_CLK) begin
      rst_q_ff <= RESET;
   end

   set_raises_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      set_wr && dp_grp_ff == '0 |=> ((g0_out & $past(HWDATA)) == $past(HWDATA)))
      else $error("set write did not raise masked bits");

   set_keeps_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      set_wr && dp_grp_ff == '0 |=>
         ((g0_out & ~$past(HWDATA)) == ($past(g0_out) & ~$past(HWDATA))))
      else $error("set write changed unmasked bits");

   views_shared_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      set_rd && addr_grp == '0 && !dp_write_ff |=> HRDATA == g0_out)
      else $error("set view differs from output value");

   view_match_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      outv_rd && addr_grp == '0 && !dp_write_ff |=> HRDATA == g0_out)
      else $error("value view differs from output storage");

   group_split_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      dp_write_ff && dp_grp_ff != '0 |=> $stable(g0_out) && $stable(g0_oe))
      else $error("write to another group touched group zero");

   group_pins_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      set_wr && dp_grp_ff == '1 |=> ((g1_pad & $past(HWDATA)) == $past(HWDATA)))
      else $error("group one set write missed its 32-pin slice");

   reset_zero_a: assert property (@(posedge SYS_CLK)
      rst_q_ff && !RESET |-> g0_out == OUT_RESET && HRDATA == RDATA_ZERO)
      else $error("output value not zero after reset");

   pull_dir_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      ((g0_pu & (g0_oe | ~g0_out)) == '0) && ((g0_pd & (g0_oe | g0_out)) == '0))
      else $error("pull chosen against output value or direction");

   okay_ready_a: assert property (@(posedge SYS_CLK) disable iff (RESET)
      !rst_q_ff |-> HREADYOUT && HRESP == HRESP_OKAY)
      else $error("bus answer not ready or not okay");
endmodule : pos_port_output_set

/* File: verif/pos_pin_load.sv */
// pin and load model at the pads of the port output block
`timescale 1ns/1ps
module pos_pin_load
   import pos_pkg::*;
(
   input  wire logic                 clk,
   input  wire logic [PIN_TOTAL-1:0] pad_out,
   input  wire logic [PIN_TOTAL-1:0] pad_oe,
   input  wire logic [PIN_TOTAL-1:0] pad_up,
   input  wire logic [PIN_TOTAL-1:0] pad_down,
   output logic      [PIN_TOTAL-1:0] pin_level
);
   logic [PIN_TOTAL-1:0] float_ff = '0;
   logic [PIN_TOTAL-1:0] nxt_float;
   logic [PIN_TOTAL-1:0] pulled;
   // a pin nobody drives or pulls wanders, so a stale level is never trusted
   assign nxt_float = ~float_ff;
   always_ff @(posedge clk) begin
      float_ff <= nxt_float;
   end
   assign pulled    = ~pad_oe & (pad_up | pad_down);
   assign pin_level = (pad_oe & pad_out) | (pulled & pad_up)
                      | (~pad_oe & ~pulled & float_ff);
endmodule : pos_pin_load

/* File: verif/tb_top.sv */
// self-checking bench for the port output set block
`timescale 1ns/1ps
module tb_top
   import pos_pkg::*;
;
   logic                 SYS_CLK = 1'b0;
   logic                 RESET   = 1'b1;
   logic                 HSEL    = 1'b1;
   logic                 HWRITE  = 1'b0;
   logic                 rd_ph   = 1'b0;
   logic [1:0]           HTRANS  = 2'h0;
   logic [2:0]           HSIZE   = 3'h2;
   logic [31:0]          HADDR   = 32'h0;
   logic [31:0]          HWDATA  = 32'h0;
   logic [31:0]          HRDATA, rnd_ff;
   logic                 HREADYOUT, HRESP;
   logic [PIN_TOTAL-1:0] PAD_OUT, PAD_OE, PAD_PULL_UP, PAD_PULL_DOWN, pin_lvl, exp_out, dir;
   logic [31:0]          exp_q[$];
   int                   error_cnt = 0;
   int                   comparisons = 0;

   always #5 SYS_CLK = ~SYS_CLK;

   pos_port_output_set pos_port_output_set_inst (.SYS_CLK(SYS_CLK), .RESET(RESET),
      .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE),
      .HWDATA(HWDATA), .HREADY(HREADYOUT), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT),
      .HRESP(HRESP), .PAD_OUT(PAD_OUT), .PAD_OE(PAD_OE), .PAD_PULL_UP(PAD_PULL_UP),
      .PAD_PULL_DOWN(PAD_PULL_DOWN));
   pos_pin_load pos_pin_load_inst (.clk(SYS_CLK), .pad_out(PAD_OUT), .pad_oe(PAD_OE),
      .pad_up(PAD_PULL_UP), .pad_down(PAD_PULL_DOWN), .pin_level(pin_lvl));

   task give_verdict;
      $display("errors %0d comparisons %0d", error_cnt, comparisons);
      if (error_cnt == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : give_verdict

   task chk(input logic [PIN_TOTAL-1:0] got, input logic [PIN_TOTAL-1:0] exp);
      comparisons++;
      if (got !== exp) begin
         error_cnt++;
         $display("FAIL %0t got %h expected %h", $time, got, exp);
      end
   endtask : chk

   function logic [31:0] xs(input logic [31:0] x);
      logic [31:0] y;
      y = x ^ (x << 13);
      y = y ^ (y >> 17);
      return y ^ (y << 5);
   endfunction : xs

   function logic [31:0] ad(input int g, input logic [OFS_W-1:0] o);
      return GROUP_STRIDE * 32'(g) + 32'(o);
   endfunction : ad

   // hready is sampled at each edge; a slave that never answers ends the run
   task wait_rdy;
      int n;
      n = 0;
      do begin
         @(posedge SYS_CLK);
         n++;
      end while (HREADYOUT !== 1'b1 && n < 20);
      if (HREADYOUT !== 1'b1) begin
         error_cnt++;
         $display("FAIL %0t bus never ready", $time);
         give_verdict();
      end
   endtask : wait_rdy

   task xfer(input logic wr, input logic [31:0] a, input logic [31:0] d);
      HTRANS <= HTRANS_NONSEQ;
      HADDR  <= a;
      HWRITE <= wr;
      wait_rdy();
      HTRANS <= 2'h0;
      HWDATA <= d;
      rd_ph  <= ~wr;
      wait_rdy();
      rd_ph  <= 1'b0;
   endtask : xfer

   task rd(input logic [31:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      xfer(1'b0, a, 32'h0);
   endtask : rd

   // read data is taken at the edge that ends the data phase
   always @(posedge SYS_CLK) begin
      if (rd_ph && HREADYOUT === 1'b1) begin
         chk({32'h0, HRDATA}, {32'h0, exp_q.pop_front()});
      end
   end

   initial begin
      int          g;
      int          k;
      logic [31:0] m;
      rnd_ff  = 32'h6443;
      exp_out = '0;
      repeat (2) @(posedge SYS_CLK);
      RESET <= 1'b0;
      @(posedge SYS_CLK);
      for (g = 0; g < NUM_GROUPS; g++) begin
         rd(ad(g, OFS_SET), 32'h0);
      end
      rd(32'h0000_0100, 32'h0);
      for (k = 0; k < 8; k++) begin
         g = k % NUM_GROUPS;
         rnd_ff = xs(rnd_ff);
         // late masks are zero so earlier ones must survive them
         m = (k >= 6) ? 32'h0 : rnd_ff;
         xfer(1'b1, ad(g, OFS_SET), m);
         exp_out[g*32 +: 32] = exp_out[g*32 +: 32] | m;
         // pads are looked at mid-cycle; the next request still starts on an edge
         @(negedge SYS_CLK) chk(PAD_OUT, exp_out);
         @(posedge SYS_CLK);
         rd(ad(g, OFS_OUT), exp_out[g*32 +: 32]);
         rd(ad(g, OFS_TGL), exp_out[g*32 +: 32]);
         rd(ad(g, OFS_SET), exp_out[g*32 +: 32]);
      end
      xfer(1'b1, ad(0, OFS_CLR), rnd_ff);
      exp_out[31:0] = exp_out[31:0] & ~rnd_ff;
      rd(ad(0, OFS_SET), exp_out[31:0]);
      xfer(1'b1, ad(1, OFS_OUT), rnd_ff);
      exp_out[63:32] = rnd_ff;
      rnd_ff = xs(rnd_ff);
      xfer(1'b1, ad(1, OFS_TGL), rnd_ff);
      exp_out[63:32] = exp_out[63:32] ^ rnd_ff;
      rd(ad(1, OFS_CLR), exp_out[63:32]);
      rd(ad(1, OFS_SET), exp_out[63:32]);
      rnd_ff = xs(rnd_ff);
      dir = {~rnd_ff, rnd_ff};
      for (g = 0; g < NUM_GROUPS; g++) begin
         xfer(1'b1, ad(g, OFS_DIR), dir[g*32 +: 32]);
         xfer(1'b1, ad(g, OFS_PULL), 32'hffff_ffff);
      end
      #1 chk(PAD_OE, dir);
      chk(PAD_OUT, exp_out);
      chk(PAD_PULL_UP, ~dir & exp_out);
      chk(PAD_PULL_DOWN, ~dir & ~exp_out);
      chk(pin_lvl, exp_out);
      give_verdict();
   end
endmodule : tb_top
